// ### logic/mic_pkg.sv
package mic_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18; // Byte address width, four times index
  localparam int DATA_W = 32; // APB data width

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_EDGE_POLARITY_SELECT = 16'hFFF2;
  localparam logic [15:0] IDX_SOURCE_ENABLE_ONE = 16'hFFF3;
  localparam logic [15:0] IDX_SOURCE_ENABLE_TWO = 16'hFFF4;
  localparam logic [15:0] IDX_REQUEST_FLAGS_ONE = 16'hFFF6;
  localparam logic [15:0] IDX_REQUEST_FLAGS_TWO = 16'hFFF7;
  localparam logic [15:0] IDX_WAKEUP_REQUEST_FLAGS = 16'hFFF9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_EDGE_POLARITY_SELECT = 8'h60;
  localparam logic [7:0] RST_SOURCE_ENABLE_ONE = 8'h00;
  localparam logic [7:0] RST_SOURCE_ENABLE_TWO = 8'h01;
  localparam logic [7:0] RST_REQUEST_FLAGS_ONE = 8'h20;
  localparam logic [7:0] RST_REQUEST_FLAGS_TWO = 8'h01;
  localparam logic [7:0] RST_WAKEUP_REQUEST_FLAGS = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NUM_EXT = 5; // External interrupt pins
  localparam int NUM_WAKE = 8; // Wakeup pins
  localparam int NUM_SERIAL_THREE = 6; // Merged serial three requests
  localparam int BIT_TIMER_A = 7; // Enable one / flags one
  localparam int BIT_SERIAL_ONE = 6;
  localparam int BIT_WAKE_GROUP = 5;
  localparam int BIT_DIRECT = 7; // Enable two / flags two
  localparam int BIT_CONVERTER = 6;
  localparam int BIT_TIMER_G = 4;
  localparam int BIT_TIMER_FH = 3;
  localparam int BIT_TIMER_FL = 2;
  localparam int BIT_EXT_TRIG_CONV = 4; // Pin shared with converter
  localparam int BIT_EXT_TRIG_TMRF = 3; // Pin shared with timer F

  // ----------------------------------------------------------------
  // Vector numbers and table geometry
  // ----------------------------------------------------------------
  localparam logic [4:0] VEC_NONE = 5'h00;
  localparam logic [4:0] VEC_EXT_BASE = 5'h04;
  localparam logic [4:0] VEC_WAKE = 5'h09;
  localparam logic [4:0] VEC_SERIAL_ONE = 5'h0A;
  localparam logic [4:0] VEC_TIMER_A = 5'h0B;
  localparam logic [4:0] VEC_TIMER_FL = 5'h0E;
  localparam logic [4:0] VEC_TIMER_FH = 5'h0F;
  localparam logic [4:0] VEC_TIMER_G = 5'h10;
  localparam logic [4:0] VEC_SERIAL_THREE = 5'h12;
  localparam logic [4:0] VEC_CONVERTER = 5'h13;
  localparam logic [4:0] VEC_DIRECT = 5'h14;
  localparam logic [15:0] VEC_ENTRY_BYTES = 16'h0002;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic timer_a_overflow; // Pulse
    logic serial_one_done; // Pulse
    logic timer_fl_compare; // Pulse
    logic timer_fl_overflow; // Pulse
    logic timer_fh_compare; // Pulse
    logic timer_fh_overflow; // Pulse
    logic timer_g_capture; // Pulse
    logic timer_g_overflow; // Pulse
    logic converter_done; // Pulse
    logic direct_transfer; // Pulse
    logic [NUM_SERIAL_THREE-1:0] serial_three_request; // Levels
  } mic_periph_type;

  typedef struct packed {
    logic request; // Level to CPU core
    logic [4:0] vector; // Vector number
    logic [15:0] address; // Vector table entry address
  } mic_cpu_type;

  typedef struct packed {
    logic converter_external_trigger; // Pulse on selected edge
    logic timer_f_event_input; // Pulse on selected edge
  } mic_trig_type;

  typedef struct packed {
    logic [NUM_EXT-1:0] ext_s1, ext_s2, ext_s3; // Ext pin sync chain
    logic [NUM_WAKE-1:0] wk_s1, wk_s2, wk_s3; // Wakeup sync chain
    logic [NUM_EXT-1:0] polarity; // Edge select per ext pin
    logic [7:0] enable_one; // Gates, timer A down to ext 0
    logic [4:0] enable_two; // Direct, conv, G, FH, FL
    logic [NUM_EXT-1:0] ext_flag;
    logic timer_a_flag, serial_one_flag;
    logic [NUM_WAKE-1:0] wake_flag;
    logic direct_flag, conv_flag, tg_flag, tfh_flag, tfl_flag;
    logic pready, pslverr;
    logic [DATA_W-1:0] prdata;
    mic_cpu_type cpu;
    mic_trig_type trig;
  } mic_state_type;

endpackage

// ### logic/mic_interrupt_controller.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Fixed priority, lower vector number wins
// - Timer FL compare/overflow share vector 14
// - Timer FH compare/overflow share vector 15
// - Timer G capture/overflow share vector 16
// - Six serial three requests merge on 18
// - Reserved vector slots are never produced
// - Write 0 clears flag, write 1 ignored
// - Polarity bit 0 falling, 1 rising
// - Edge select bit7 reads 0, bits6-5 read 1
// - Ext 4/3 polarity drives shared trigger pins
// - Enable one bit 7 gates timer A
// - Enable one bit 6 gates serial one
// - Enable one bit 5 gates wakeup group
// - Enable one bits 4-0 gate ext pins
// - Enable 0 blocks, 1 passes, reset 0
// - Mask set: flags still set, no request
// - Ext flag sets on selected edge when input
// - Acceptance never clears a flag
module mic_interrupt_controller (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mic_pkg::ADDR_W-1:0] paddr,
  input wire logic [mic_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [mic_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [mic_pkg::NUM_EXT-1:0] ext_int_pin,
  input wire logic [mic_pkg::NUM_EXT-1:0] ext_int_pin_is_input,
  input wire logic [mic_pkg::NUM_WAKE-1:0] wakeup_pin,
  input wire mic_pkg::mic_periph_type periph,
  input wire logic cpu_int_mask,
  output mic_pkg::mic_cpu_type cpu,
  output mic_pkg::mic_trig_type trig
);
  import mic_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mic_state_type state; // Registered state
  mic_state_type next_state; // Next value

  // Outputs come straight from flops
  // No output is ever combinational, so the core and the bus
  // master see values that settle at the clock edge only
  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign cpu = state.cpu;
  assign trig = state.trig;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Timing in clock edges:
  //   pin change to flag is three edges (two sync stages plus the
  //   edge flop), and one more to the core request
  //   peripheral pulse to flag is one edge, request one edge later
  //   serial three level to request is one edge
  // A flag set and a clear in one cycle keep the flag, so an
  // event that lands on a software clear is never lost
  always_comb begin
    logic [15:0] idx; // Register index from address
    logic aligned; // Word-aligned access
    logic setup; // APB setup cycle
    logic wr_done; // Completing write with low lane enabled
    logic [7:0] wbyte; // Written byte
    logic [7:0] rbyte; // Read byte
    logic hit; // Mapped index
    logic [NUM_EXT-1:0] rise; // Settled rising edges
    logic [NUM_EXT-1:0] fall; // Settled falling edges
    logic [NUM_EXT-1:0] ext_edge; // Edge of the selected polarity
    logic [NUM_WAKE-1:0] wk_fall; // Wakeup pin went low
    logic [7:0] clr1; // Clear mask, flags one
    logic [7:0] clr2; // Clear mask, flags two
    logic [7:0] clrw; // Clear mask, wakeup flags
    logic g_ext; // Some gated ext pin
    logic g_wake; // Gated wakeup group
    logic g_s1; // Gated serial one
    logic g_ta; // Gated timer A
    logic g_tfl; // Gated timer FL
    logic g_tfh; // Gated timer FH
    logic g_tg; // Gated timer G
    logic g_s3; // Serial three, merged
    logic g_ad; // Gated converter
    logic g_dt; // Gated direct transfer
    logic [4:0] vec; // Winning vector
    logic any; // Any gated request
    next_state = state;
    idx = paddr[ADDR_W-1:2];
    aligned = (paddr[1:0] == 2'b00);
    setup = psel && !penable;
    wr_done = psel && penable && state.pready && pwrite && pstrb[0]
      && aligned;
    wbyte = pwdata[7:0];
    rbyte = 8'h00;
    hit = 1'b1;
    clr1 = 8'h00;
    clr2 = 8'h00;
    clrw = 8'h00;
    g_ext = 1'b0;
    vec = VEC_NONE;
    any = 1'b0;
    // Defaults so no path leaves a temporary unassigned
    rise = '0;
    fall = '0;
    ext_edge = '0;
    wk_fall = '0;
    g_wake = 1'b0;
    g_s1 = 1'b0;
    g_ta = 1'b0;
    g_tfl = 1'b0;
    g_tfh = 1'b0;
    g_tg = 1'b0;
    g_s3 = 1'b0;
    g_ad = 1'b0;
    g_dt = 1'b0;


    // Pins are treated as asynchronous here even though the bench
    // drives them on the clock; a third stage holds the old level
    // Pin synchronisers; first stage feeds only the second
    next_state.ext_s1 = ext_int_pin;
    next_state.ext_s2 = state.ext_s1;
    next_state.ext_s3 = state.ext_s2;
    next_state.wk_s1 = wakeup_pin;
    next_state.wk_s2 = state.wk_s1;
    next_state.wk_s3 = state.wk_s2;


    // Only the second and third stages are compared, so a pin that
    // stays at one level never yields a second edge
    // Edge detection on settled samples, polarity per pin
    rise = state.ext_s2 & ~state.ext_s3;
    fall = ~state.ext_s2 & state.ext_s3;
    for (int n = 0; n < NUM_EXT; n++) begin
      ext_edge[n] = state.polarity[n] ? rise[n] : fall[n];
    end
    wk_fall = ~state.wk_s2 & state.wk_s3; // Wakeup pins active low


    // Trigger pulses ignore the input configuration: the converter
    // and timer F still see their pin when it is not an interrupt
    // Shared pins see the same selected edge
    next_state.trig.converter_external_trigger =
      ext_edge[BIT_EXT_TRIG_CONV];
    next_state.trig.timer_f_event_input =
      ext_edge[BIT_EXT_TRIG_TMRF];


    // Reserved bits are built in here as constants, so software
    // always reads their fixed level whatever it wrote
    // Read mux, evaluated in the setup cycle
    case (idx)
      IDX_EDGE_POLARITY_SELECT: begin
        rbyte = {3'b011, state.polarity};
      end
      IDX_SOURCE_ENABLE_ONE: begin
        rbyte = state.enable_one;
      end
      IDX_SOURCE_ENABLE_TWO: begin
        rbyte = {state.enable_two[4:3], 1'b0, state.enable_two[2:0],
          2'b01};
      end
      IDX_REQUEST_FLAGS_ONE: begin
        rbyte = {state.timer_a_flag, state.serial_one_flag, 1'b1,
          state.ext_flag};
      end
      IDX_REQUEST_FLAGS_TWO: begin
        rbyte = {state.direct_flag, state.conv_flag, 1'b0,
          state.tg_flag, state.tfh_flag, state.tfl_flag, 2'b01};
      end
      IDX_WAKEUP_REQUEST_FLAGS: begin
        rbyte = state.wake_flag;
      end
      default: begin
        hit = 1'b0; // Unmapped
      end
    endcase


    // Every transfer takes two cycles; read data is latched at the
    // setup edge, so a flag set during access shows next read
    // APB answer: ready in the first access cycle, then drop
    if (setup) begin
      next_state.pready = 1'b1;
      next_state.pslverr = !(hit && aligned);
      next_state.prdata = (hit && aligned && !pwrite) ?
        {24'h000000, rbyte} : '0;
    end else begin
      next_state.pready = 1'b0;
      next_state.pslverr = 1'b0;
      next_state.prdata = '0;
    end


    // Writes with the low byte lane off, or to an unaligned or
    // unmapped word, leave every register as it was
    // Register writes take effect at the completing edge
    if (wr_done && hit) begin
      case (idx)
        IDX_EDGE_POLARITY_SELECT: begin
          next_state.polarity = wbyte[NUM_EXT-1:0];
        end
        IDX_SOURCE_ENABLE_ONE: begin
          next_state.enable_one = wbyte;
        end
        IDX_SOURCE_ENABLE_TWO: begin
          next_state.enable_two = {wbyte[7:6], wbyte[4:2]};
        end
        IDX_REQUEST_FLAGS_ONE: begin
          clr1 = ~wbyte;
        end
        IDX_REQUEST_FLAGS_TWO: begin
          clr2 = ~wbyte;
        end
        IDX_WAKEUP_REQUEST_FLAGS: begin
          clrw = ~wbyte;
        end
        default: begin
          clr1 = 8'h00;
        end
      endcase
    end


    // Writing 1 to a flag only keeps it; there is no way for
    // software to raise a request by itself
    // Flags: set wins over clear; acceptance leaves them alone
    for (int n = 0; n < NUM_EXT; n++) begin
      next_state.ext_flag[n] = (state.ext_flag[n] & ~clr1[n])
        | (ext_edge[n] & ext_int_pin_is_input[n]);
    end
    next_state.wake_flag = (state.wake_flag & ~clrw) | wk_fall;
    next_state.timer_a_flag = (state.timer_a_flag & ~clr1[BIT_TIMER_A])
      | periph.timer_a_overflow;
    next_state.serial_one_flag =
      (state.serial_one_flag & ~clr1[BIT_SERIAL_ONE])
      | periph.serial_one_done;
    next_state.direct_flag = (state.direct_flag & ~clr2[BIT_DIRECT])
      | periph.direct_transfer;
    next_state.conv_flag = (state.conv_flag & ~clr2[BIT_CONVERTER])
      | periph.converter_done;
    next_state.tg_flag = (state.tg_flag & ~clr2[BIT_TIMER_G])
      | periph.timer_g_capture | periph.timer_g_overflow;
    next_state.tfh_flag = (state.tfh_flag & ~clr2[BIT_TIMER_FH])
      | periph.timer_fh_compare | periph.timer_fh_overflow;
    next_state.tfl_flag = (state.tfl_flag & ~clr2[BIT_TIMER_FL])
      | periph.timer_fl_compare | periph.timer_fl_overflow;


    // A blocked flag stays pending and raises a request as soon as
    // its enable is written to 1
    // Gating: enable 1 passes, 0 blocks
    g_wake = (|state.wake_flag) & state.enable_one[BIT_WAKE_GROUP];
    g_s1 = state.serial_one_flag
      & state.enable_one[BIT_SERIAL_ONE];
    g_ta = state.timer_a_flag & state.enable_one[BIT_TIMER_A];
    g_dt = state.direct_flag & state.enable_two[4];
    g_ad = state.conv_flag & state.enable_two[3];
    g_tg = state.tg_flag & state.enable_two[2];
    g_tfh = state.tfh_flag & state.enable_two[1];
    g_tfl = state.tfl_flag & state.enable_two[0];
    g_s3 = |periph.serial_three_request;


    // Written as a chain of ifs so that adding a source means
    // slotting in one more line at its place in the order
    // Priority search from lowest priority upward; last hit wins
    if (g_dt) begin
      vec = VEC_DIRECT;
    end
    if (g_ad) begin
      vec = VEC_CONVERTER;
    end
    if (g_s3) begin
      vec = VEC_SERIAL_THREE;
    end
    if (g_tg) begin
      vec = VEC_TIMER_G;
    end
    if (g_tfh) begin
      vec = VEC_TIMER_FH;
    end
    if (g_tfl) begin
      vec = VEC_TIMER_FL;
    end
    if (g_ta) begin
      vec = VEC_TIMER_A;
    end
    if (g_s1) begin
      vec = VEC_SERIAL_ONE;
    end
    if (g_wake) begin
      vec = VEC_WAKE;
    end
    for (int n = NUM_EXT - 1; n >= 0; n--) begin
      if (state.ext_flag[n] && state.enable_one[n]) begin
        g_ext = 1'b1;
        vec = VEC_EXT_BASE + 5'(n);
      end
    end
    any = g_ext | g_wake | g_s1 | g_ta | g_tfl | g_tfh | g_tg | g_s3
      | g_ad | g_dt;


    // Vector and entry address read zero while no request stands,
    // so the core never latches a stale slot
    // Only listed vectors reach the core; masked means no request
    next_state.cpu.request = any && !cpu_int_mask;
    next_state.cpu.vector = next_state.cpu.request ? vec : VEC_NONE;
    next_state.cpu.address = next_state.cpu.request ?
      16'({11'h000, vec} * VEC_ENTRY_BYTES) : 16'h0000;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    // Synchronous reset to the documented values
    if (reset) begin
      // Flags, enables and bus answer all clear
      state <= '0;
      // Pin chains start at the idle high level of the pins, so no
      // false edge follows the release of reset
      state.ext_s1 <= '1;
      state.ext_s2 <= '1;
      state.ext_s3 <= '1;
      state.wk_s1 <= '1;
      state.wk_s2 <= '1;
      state.wk_s3 <= '1;
      state.polarity <= RST_EDGE_POLARITY_SELECT[NUM_EXT-1:0];
      state.enable_one <= RST_SOURCE_ENABLE_ONE;
      state.enable_two <= 5'h00;
    end else begin
      state <= next_state;
    end
  end

endmodule

`default_nettype wire

// ### verification/mic_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

// Core side: takes the vector, masks itself, waits for a resume
module mic_cpu_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire mic_pkg::mic_cpu_type cpu,
  input wire logic slow,
  input wire logic resume,
  output logic cpu_int_mask,
  output logic taken,
  output logic [4:0] taken_vec
);
  import mic_pkg::*;
  logic [1:0] wait_cnt; // Slow acceptance delay
  // ----
  // Mask set at reset and on entry, cleared on return
  // ----
  always_ff @(posedge clk_sys) begin
    taken <= 1'b0;
    if (reset) begin
      cpu_int_mask <= 1'b1;
      wait_cnt <= 2'd0;
      taken_vec <= 5'h00;
    end else if (resume) begin
      cpu_int_mask <= 1'b0;
    end else if (cpu.request && !cpu_int_mask) begin
      wait_cnt <= wait_cnt + 2'd1;
      // Prompt, or after four cycles when slow
      if (!slow || wait_cnt == 2'd3) begin
        cpu_int_mask <= 1'b1;
        taken <= 1'b1;
        taken_vec <= cpu.vector;
        wait_cnt <= 2'd0;
      end
    end
  end
endmodule

`default_nettype wire

// ### verification/mic_interrupt_controller_properties.sv
`timescale 1ns/10ps
`default_nettype none

// Port-level checks of the controller
module mic_interrupt_controller_properties (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pwrite,
  input wire logic [mic_pkg::ADDR_W-1:0] paddr,
  input wire logic [mic_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [mic_pkg::NUM_EXT-1:0] ext_int_pin,
  input wire mic_pkg::mic_periph_type periph,
  input wire logic cpu_int_mask,
  input wire mic_pkg::mic_cpu_type cpu,
  input wire mic_pkg::mic_trig_type trig
);
  import mic_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----
  // Vector output
  // ----
  property p_addr;
    cpu.request |-> cpu.address == {10'h000, cpu.vector, 1'b0};
  endproperty
  a_addr: assert property (p_addr) else $error("bad entry");
  property p_reserved;
    cpu.request |-> cpu.vector inside {[5'd4:5'd11], [5'd14:5'd16],
      [5'd18:5'd20]};
  endproperty
  a_reserved: assert property (p_reserved) else $error("bad slot");
  property p_idle;
    !cpu.request |-> cpu.vector == 5'h00 && cpu.address == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("idle vector");
  property p_mask;
    cpu_int_mask |=> !cpu.request;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request");
  property p_serial3;
    |periph.serial_three_request && !cpu_int_mask |=>
      cpu.request && cpu.vector <= 5'd18;
  endproperty
  a_serial3: assert property (p_serial3) else $error("merge");
  // ----
  // Registers and shared pins
  // ----
  property p_edge_read;
    pready && !pwrite && !pslverr &&
      paddr == {IDX_EDGE_POLARITY_SELECT, 2'b00} |-> prdata[7:5] == 3'b011;
  endproperty
  a_edge_read: assert property (p_edge_read) else $error("fixed");
  property p_trig_pulse;
    trig.converter_external_trigger |=> !trig.converter_external_trigger;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("long");
  property p_trig_cause;
    trig.timer_f_event_input |->
      $past(ext_int_pin[3], 2) != $past(ext_int_pin[3], 5);
  endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("cause");
endmodule

bind mic_interrupt_controller mic_interrupt_controller_properties u_props (
  .clk_sys, .reset, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .ext_int_pin, .periph, .cpu_int_mask, .cpu, .trig);

`default_nettype wire

// ### verification/mic_interrupt_controller_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("unexpected at %0t: got %h not %h", $time, g, e); \
  end end

module mic_interrupt_controller_bench;
  import mic_pkg::*;
  // ----
  // Stimulus and observation
  // ----
  logic clk_sys = 1'b0, reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF; // Full-word strobes
  logic [NUM_EXT-1:0] ext_int_pin = '1, ext_int_pin_is_input = '1;
  logic [NUM_WAKE-1:0] wakeup_pin = '1; // Idle high
  mic_periph_type periph = '0;
  logic cpu_int_mask, slow = 1'b0, resume = 1'b0, taken;
  logic [4:0] taken_vec;
  mic_cpu_type cpu;
  mic_trig_type trig;
  int failures = 0, samples_checked = 0;
  logic [9:0] p; // Peripheral pulse pattern
  always #2 clk_sys = ~clk_sys;
  mic_interrupt_controller dut (.clk_sys, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .ext_int_pin, .ext_int_pin_is_input, .wakeup_pin, .periph,
    .cpu_int_mask, .cpu, .trig);
  mic_cpu_model cpu_core (.clk_sys, .reset, .cpu, .slow, .resume,
    .cpu_int_mask, .taken, .taken_vec);
  // ----
  // Bus and core tasks
  // ----
  task automatic apb(input logic w, input logic [17:0] a,
    input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge clk_sys);
    // Hung bus ends the run
    if (pready !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask
  task automatic rdc(input logic [15:0] i, input logic [7:0] e);
    apb(1'b0, {i, 2'b00}, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask
  task automatic clear_all();
    wr(IDX_REQUEST_FLAGS_ONE, 8'h00);
    wr(IDX_REQUEST_FLAGS_TWO, 8'h00);
    wr(IDX_WAKEUP_REQUEST_FLAGS, 8'h00);
  endtask
  // Unmask the core, then wait a bounded time for acceptance
  task automatic take(input logic [4:0] v);
    int n;
    resume <= 1'b1;
    slow <= 1'($urandom_range(0, 1));
    @(posedge clk_sys);
    resume <= 1'b0;
    for (n = 0; n < 40 && taken !== 1'b1; n++) @(posedge clk_sys);
    if (taken !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
    `CHK(taken_vec, v)
  endtask
  // Priority of a pulse pattern, timer A down to direct transfer
  function automatic logic [4:0] exp_vec(input logic [9:0] q);
    if (q[8]) return 5'd10;
    if (q[9]) return 5'd11;
    if (|q[7:6]) return 5'd14;
    if (|q[5:4]) return 5'd15;
    if (|q[3:2]) return 5'd16;
    if (q[1]) return 5'd19;
    return 5'd20;
  endfunction
  task automatic tally_and_finish();
    $display("failures %0d samples %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    int n;
    int k;
    logic pol;
    void'($urandom(32'hDC3E));
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdc(IDX_EDGE_POLARITY_SELECT, 8'h60);
    rdc(IDX_SOURCE_ENABLE_ONE, 8'h00);
    rdc(IDX_SOURCE_ENABLE_TWO, 8'h01);
    rdc(IDX_REQUEST_FLAGS_ONE, 8'h20);
    rdc(IDX_REQUEST_FLAGS_TWO, 8'h01);
    rdc(IDX_WAKEUP_REQUEST_FLAGS, 8'h00);
    apb(1'b0, 18'h00004, 8'h00);
    `CHK(err, 1'b1)
    wr(IDX_EDGE_POLARITY_SELECT, 8'hFF);
    rdc(IDX_EDGE_POLARITY_SELECT, 8'h7F);
    // Each pin, both edges; masked and gated first
    for (n = 0; n < NUM_EXT; n++) begin
      for (k = 0; k < 2; k++) begin
        pol = k[0];
        wr(IDX_EDGE_POLARITY_SELECT, 8'(pol) << n);
        wr(IDX_SOURCE_ENABLE_ONE, 8'h00);
        ext_int_pin[n] <= !pol;
        repeat (6) @(posedge clk_sys);
        clear_all();
        ext_int_pin[n] <= pol;
        repeat (8) @(posedge clk_sys);
        `CHK(cpu.request, 1'b0)
        rdc(IDX_REQUEST_FLAGS_ONE, 8'h20 | (8'h01 << n));
        wr(IDX_SOURCE_ENABLE_ONE, 8'h01 << n);
        take(5'd4 + 5'(n));
        rdc(IDX_REQUEST_FLAGS_ONE, 8'h20 | (8'h01 << n));
        wr(IDX_REQUEST_FLAGS_ONE, ~(8'h01 << n));
        rdc(IDX_REQUEST_FLAGS_ONE, 8'h20);
        ext_int_pin[n] <= !pol;
        repeat (8) @(posedge clk_sys);
        rdc(IDX_REQUEST_FLAGS_ONE, 8'h20);
      end
    end
    // Pins not configured as inputs set nothing
    ext_int_pin_is_input <= '0;
    wr(IDX_EDGE_POLARITY_SELECT, 8'h1F);
    ext_int_pin <= '1;
    repeat (8) @(posedge clk_sys);
    rdc(IDX_REQUEST_FLAGS_ONE, 8'h20);
    ext_int_pin_is_input <= '1;
    wr(IDX_SOURCE_ENABLE_ONE, 8'hE0);
    wr(IDX_SOURCE_ENABLE_TWO, 8'hDC);
    rdc(IDX_SOURCE_ENABLE_TWO, 8'hDD);
    // Single sources, then random mixes
    for (n = 0; n < 16; n++) begin
      p = (n < 10) ? 10'h001 << n : 10'($urandom);
      if (p == 10'h000) p = 10'h200;
      clear_all();
      periph[15:6] <= p;
      @(posedge clk_sys);
      periph <= '0;
      take(exp_vec(p));
      rdc(IDX_REQUEST_FLAGS_ONE, {p[9], p[8], 6'h20});
      rdc(IDX_REQUEST_FLAGS_TWO, {p[0], p[1], 1'b0, |p[3:2], |p[5:4],
        |p[7:6], 2'b01});
    end
    for (n = 0; n < 3; n++) begin
      k = $urandom_range(0, 7);
      clear_all();
      wakeup_pin[k] <= 1'b0;
      take(5'd9);
      rdc(IDX_WAKEUP_REQUEST_FLAGS, 8'h01 << k);
      wakeup_pin <= '1;
    end
    clear_all();
    for (k = 0; k < NUM_SERIAL_THREE; k++) begin
      periph.serial_three_request <= 6'h01 << k;
      take(5'd18);
    end
    periph <= '0;
    tally_and_finish();
  end
endmodule

`default_nettype wire
